//--- src/sdram_cfg_lowpower.sv
// Purpose: Geometry/timing config, low-power sequencing and refresh irq
// Assumes: Access datapath reports issued commands as one-cycle pulses
// Notes: Registers over a plain port, read data one cycle after strobe
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sdram_cfg_lowpower
    import sdram_cfg_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic access_req_in,
    input wire logic transfer_busy_in,
    input wire logic write_done_in,
    input wire logic refresh_issued_in,
    input wire logic precharge_issued_in,
    input wire logic activate_issued_in,
    input wire logic refresh_error_in,
    output logic [3:0] row_bits_out,
    output logic four_banks_out,
    output logic [1:0] cas_latency_out,
    output logic bus16_out,
    output logic [6:0] ext_mode_out,
    output logic cmd_allowed_out,
    output logic activate_allowed_out,
    output logic rw_allowed_out,
    output logic precharge_allowed_out,
    output logic self_refresh_cmd_out,
    output logic power_down_cmd_out,
    output logic deep_pd_cmd_out,
    output logic memory_clk_en_out,
    output logic memory_clock_run_out,
    output logic lp_ready_out,
    output logic irq_out
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [31:0] geom_ff;
    logic [31:0] lowpwr_ff;
    logic irq_mask_ff;
    logic err_flag_ff;
    logic nxt_err_flag;
    logic wr_geom;
    logic wr_lowpwr;
    logic wr_en;
    logic wr_dis;
    logic rd_stat;
    logic [31:0] nxt_rdata;

    assign wr_geom = reg_wr_in && (reg_addr_in == ADDR_GEOM);
    assign wr_lowpwr = reg_wr_in && (reg_addr_in == ADDR_LOWPWR);
    assign wr_en = reg_wr_in && (reg_addr_in == ADDR_IRQ_EN);
    assign wr_dis = reg_wr_in && (reg_addr_in == ADDR_IRQ_DIS);
    assign rd_stat = reg_rd_in && (reg_addr_in == ADDR_IRQ_STAT);

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            geom_ff <= GEOM_RESET;
        end else if (wr_geom) begin
            geom_ff <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lowpwr_ff <= LOWPWR_RESET;
        end else if (wr_lowpwr) begin
            lowpwr_ff <= reg_wdata_in & LOWPWR_WMASK;
        end
    end

    // ------------------------------------------------------------
    // Interrupt mask and refresh error flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_mask_ff <= 1'b0;
        end else if (wr_en && reg_wdata_in[IRQ_BIT]) begin
            irq_mask_ff <= 1'b1;
        end else if (wr_dis && reg_wdata_in[IRQ_BIT]) begin
            irq_mask_ff <= 1'b0;
        end
    end

    // New error in the clearing read cycle survives
    assign nxt_err_flag = refresh_error_in || (err_flag_ff && !rd_stat);

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            err_flag_ff <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            err_flag_ff <= nxt_err_flag;
            irq_out <= nxt_err_flag && irq_mask_ff;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb begin
        nxt_rdata = 32'h00000000;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_GEOM: nxt_rdata = geom_ff;
                ADDR_LOWPWR: nxt_rdata = lowpwr_ff;
                ADDR_IRQ_MASK: nxt_rdata[IRQ_BIT] = irq_mask_ff;
                ADDR_IRQ_STAT: nxt_rdata[IRQ_BIT] = err_flag_ff;
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Geometry decode
    // ------------------------------------------------------------
    logic [1:0] row_bits_sel;
    logic [1:0] cas_sel;
    assign row_bits_sel = geom_ff[ROW_LSB +: 2];
    assign cas_sel = geom_ff[CAS_LSB +: 2];

    // Reserved codes fall back to the reset geometry
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            row_bits_out <= 4'hb;
            four_banks_out <= 1'b0;
            cas_latency_out <= 2'h2;
            bus16_out <= 1'b1;
        end else begin
            unique case (row_bits_sel)
                2'b01: row_bits_out <= 4'hc;
                2'b10: row_bits_out <= 4'hd;
                default: row_bits_out <= 4'hb;
            endcase
            four_banks_out <= geom_ff[BANK_BIT];
            cas_latency_out <= (cas_sel == 2'b00) ? 2'h2 : cas_sel;
            bus16_out <= geom_ff[DBW_BIT];
        end
    end

    // Values for the extended mode load during initialization
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ext_mode_out <= '0;
        end else begin
            ext_mode_out <= {lowpwr_ff[DS_LSB +: 2],
                             lowpwr_ff[TEMP_COMP_SEL_LSB +: 2],
                             lowpwr_ff[PARTIAL_ARRAY_SEL_LSB +: 3]};
        end
    end

    // ------------------------------------------------------------
    // Command spacing timers
    // ------------------------------------------------------------
    cmd_timer_if #(.N(NUM_TIMERS), .W(4)) tif ();
    logic sr_wake;
    logic nxt_cmd_ok;
    logic [NUM_TIMERS-1:0] rdy;

    assign tif.start[T_WR] = write_done_in;
    assign tif.start[T_RC] = refresh_issued_in;
    assign tif.start[T_RP] = precharge_issued_in;
    assign tif.start[T_RCD] = activate_issued_in;
    assign tif.start[T_RAS] = activate_issued_in;
    assign tif.start[T_XSR] = sr_wake;
    assign tif.len[T_WR] = geom_ff[TWR_LSB +: 4];
    assign tif.len[T_RC] = geom_ff[TRC_LSB +: 4];
    assign tif.len[T_RP] = geom_ff[TRP_LSB +: 4];
    assign tif.len[T_RCD] = geom_ff[ROW_TO_COLUMN_CYCLES_LSB +: 4];
    assign tif.len[T_RAS] = geom_ff[ACTIVE_TO_PRECHARGE_CYCLES_LSB +: 4];
    assign tif.len[T_XSR] = geom_ff[SELF_REFRESH_EXIT_CYCLES_LSB +: 4];
    assign rdy = tif.ready_next;

    cmd_timer_bank #(.N(NUM_TIMERS), .W(4)) u_timers (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .tif(tif)
    );

    assign nxt_cmd_ok = rdy[T_WR] && rdy[T_RP];

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cmd_allowed_out <= 1'b1;
            activate_allowed_out <= 1'b1;
            rw_allowed_out <= 1'b1;
            precharge_allowed_out <= 1'b1;
        end else begin
            cmd_allowed_out <= nxt_cmd_ok;
            activate_allowed_out <= nxt_cmd_ok && rdy[T_RC] && rdy[T_XSR];
            rw_allowed_out <= nxt_cmd_ok && rdy[T_RCD];
            precharge_allowed_out <= nxt_cmd_ok && rdy[T_RAS];
        end
    end

    // ------------------------------------------------------------
    // Low-power sequencer
    // ------------------------------------------------------------
    lp_state_e state_ff;
    lp_mode_e lp_sel;
    logic idle_expired;
    logic lp_enter;

    assign lp_sel = lp_mode_e'(lowpwr_ff[LPS_LSB +: 2]);

    idle_timer u_idle (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .busy_in(transfer_busy_in || access_req_in),
        .code_in(lowpwr_ff[TOUT_LSB +: 2]),
        .expired_out(idle_expired)
    );

    // Entry waits for pending write-recovery and precharge spacing to run out
    assign lp_enter = (state_ff == ST_ACTIVE) && (lp_sel != LP_OFF) &&
                      idle_expired && nxt_cmd_ok;
    assign sr_wake = (state_ff == ST_SELF_REF) &&
                     (access_req_in || lp_sel != LP_SELF_REFRESH);

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff <= ST_ACTIVE;
            self_refresh_cmd_out <= 1'b0;
            power_down_cmd_out <= 1'b0;
            deep_pd_cmd_out <= 1'b0;
            memory_clk_en_out <= 1'b1;
            memory_clock_run_out <= 1'b1;
            lp_ready_out <= 1'b1;
        end else begin
            self_refresh_cmd_out <= 1'b0;
            power_down_cmd_out <= 1'b0;
            deep_pd_cmd_out <= 1'b0;
            unique case (state_ff)
                ST_ACTIVE: begin
                    if (lp_enter) begin
                        memory_clk_en_out <= 1'b0;
                        lp_ready_out <= 1'b0;
                        unique case (lp_sel)
                            LP_SELF_REFRESH: begin
                                state_ff <= ST_SELF_REF;
                                self_refresh_cmd_out <= 1'b1;
                                memory_clock_run_out <= 1'b0;
                            end
                            LP_POWER_DOWN: begin
                                state_ff <= ST_PWR_DOWN;
                                power_down_cmd_out <= 1'b1;
                            end
                            default: begin
                                state_ff <= ST_DEEP_PD;
                                deep_pd_cmd_out <= 1'b1;
                                memory_clock_run_out <= 1'b0;
                            end
                        endcase
                    end
                end
                ST_SELF_REF: begin
                    if (sr_wake) begin
                        state_ff <= ST_ACTIVE;
                        memory_clk_en_out <= 1'b1;
                        memory_clock_run_out <= 1'b1;
                        lp_ready_out <= 1'b1;
                    end
                end
                ST_PWR_DOWN: begin
                    if (access_req_in || lp_sel != LP_POWER_DOWN) begin
                        state_ff <= ST_ACTIVE;
                        memory_clk_en_out <= 1'b1;
                        lp_ready_out <= 1'b1;
                    end
                end
                ST_DEEP_PD: begin
                    // Contents are lost; only a mode change wakes it
                    if (lp_sel != LP_DEEP_PD) begin
                        state_ff <= ST_ACTIVE;
                        memory_clk_en_out <= 1'b1;
                        memory_clock_run_out <= 1'b1;
                        lp_ready_out <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);

    row_decode_a: assert property (
        wr_geom && reg_wdata_in[ROW_LSB +: 2] == 2'b01 |=> ##1
        row_bits_out == 4'hc) else $error("row bits decode wrong");
    bank_follow_a: assert property (
        wr_geom |=> ##1 four_banks_out == $past(reg_wdata_in[BANK_BIT], 2))
        else $error("bank count not taken");
    cas_decode_a: assert property (
        wr_geom && reg_wdata_in[CAS_LSB +: 2] == 2'b11 |=> ##1
        cas_latency_out == 2'h3) else $error("latency decode wrong");
    width_follow_a: assert property (
        wr_geom |=> ##1 bus16_out == $past(reg_wdata_in[DBW_BIT], 2))
        else $error("bus width not taken");
    wr_recovery_a: assert property (
        write_done_in && geom_ff[TWR_LSB +: 4] == 4'h2 |=>
        !cmd_allowed_out [*2]) else $error("write recovery too short");
    rcd_hold_a: assert property (
        activate_issued_in && geom_ff[ROW_TO_COLUMN_CYCLES_LSB +: 4] == 4'h2 |=>
        !rw_allowed_out [*2]) else $error("row to column too short");
    lp_off_a: assert property (
        lp_sel == LP_OFF && state_ff == ST_ACTIVE |=>
        !self_refresh_cmd_out && !power_down_cmd_out && !deep_pd_cmd_out)
        else $error("low-power command while inhibited");
    sr_enter_a: assert property (
        self_refresh_cmd_out |-> !memory_clk_en_out && !memory_clock_run_out
        && $past(lp_sel) == LP_SELF_REFRESH) else $error("bad self-refresh");
    pd_wake_a: assert property (
        state_ff == ST_PWR_DOWN && access_req_in |=> memory_clk_en_out
        && lp_ready_out) else $error("power-down not left on access");
    mask_set_a: assert property (
        wr_en && reg_wdata_in[IRQ_BIT] |=> irq_mask_ff)
        else $error("enable did not set mask");
    mask_clear_a: assert property (
        wr_dis && reg_wdata_in[IRQ_BIT] |=> !irq_mask_ff)
        else $error("disable did not clear mask");
    stat_clear_a: assert property (
        rd_stat && !refresh_error_in |=> !err_flag_ff ##1 !reg_rdata_out[0]
        or refresh_error_in) else $error("status read did not clear");
    irq_level_a: assert property (
        ##1 irq_out == ($past(nxt_err_flag) && $past(irq_mask_ff)))
        else $error("interrupt output mismatch");

    sr_cycle_c: cover property (self_refresh_cmd_out ##[1:50] sr_wake);
    pd_cycle_c: cover property (power_down_cmd_out ##[1:50] lp_ready_out);
    irq_fire_c: cover property (refresh_error_in ##[1:10] irq_out);
    dpd_entry_c: cover property (deep_pd_cmd_out);
endmodule : sdram_cfg_lowpower
`default_nettype wire

//--- src/sdram_cfg_pkg.sv
// Purpose: Shared constants for the SDRAM configuration/low-power block
// Assumes: One clock domain, plain register port with byte addresses
// Notes: Field positions are bit indices within 32-bit registers
package sdram_cfg_pkg;
    localparam logic [7:0] ADDR_GEOM = 8'h08;
    localparam logic [7:0] ADDR_LOWPWR = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_IRQ_DIS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
    localparam logic [31:0] GEOM_RESET = 32'h852372c0;
    localparam logic [31:0] LOWPWR_RESET = 32'h00000000;
    localparam logic [31:0] LOWPWR_WMASK = 32'h00003f73;
    localparam int ROW_LSB = 2;
    localparam int BANK_BIT = 4;
    localparam int CAS_LSB = 5;
    localparam int DBW_BIT = 7;
    localparam int TWR_LSB = 8;
    localparam int TRC_LSB = 12;
    localparam int TRP_LSB = 16;
    localparam int ROW_TO_COLUMN_CYCLES_LSB = 20;
    localparam int ACTIVE_TO_PRECHARGE_CYCLES_LSB = 24;
    localparam int SELF_REFRESH_EXIT_CYCLES_LSB = 28;
    localparam int LPS_LSB = 0;
    localparam int PARTIAL_ARRAY_SEL_LSB = 4;
    localparam int TEMP_COMP_SEL_LSB = 8;
    localparam int DS_LSB = 10;
    localparam int TOUT_LSB = 12;
    localparam int IRQ_BIT = 0;
    localparam logic [7:0] IDLE_SHORT = 8'h40;
    localparam logic [7:0] IDLE_LONG = 8'h80;
    localparam int NUM_TIMERS = 6;
    localparam int T_WR = 0;
    localparam int T_RC = 1;
    localparam int T_RP = 2;
    localparam int T_RCD = 3;
    localparam int T_RAS = 4;
    localparam int T_XSR = 5;
    typedef enum logic [1:0] {
        LP_OFF, LP_SELF_REFRESH, LP_POWER_DOWN, LP_DEEP_PD
    } lp_mode_e;
    typedef enum logic [1:0] {
        ST_ACTIVE, ST_SELF_REF, ST_PWR_DOWN, ST_DEEP_PD
    } lp_state_e;
endpackage : sdram_cfg_pkg

//--- src/cmd_timer_if.sv
// Purpose: Carries timer start pulses, lengths and ready flags
// Assumes: One clock domain
// Notes: ready_next is the allowed state for the coming cycle
`timescale 1ns/1ps
`default_nettype none
interface cmd_timer_if #(parameter int N = 6, parameter int W = 4);
    logic [N-1:0] start;
    logic [W-1:0] len [N];
    logic [N-1:0] ready_next;
    modport ctrl (output start, output len, input ready_next);
    modport bank (input start, input len, output ready_next);
endinterface : cmd_timer_if
`default_nettype wire

//--- src/cmd_timer_bank.sv
// Purpose: Down counters spacing memory commands
// Assumes: Start pulses one cycle wide
// Notes: Length N blocks the N cycles after the start cycle
`timescale 1ns/1ps
`default_nettype none
module cmd_timer_bank #(
    parameter int N = 6,
    parameter int W = 4
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    cmd_timer_if.bank tif
);
    if (N < 1 || W < 1) begin : g_bad
        $error("cmd_timer_bank needs N and W of at least one");
    end
    for (genvar i = 0; i < N; i++) begin : g_tmr
        logic [W-1:0] cnt_ff;
        always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                cnt_ff <= '0;
            end else if (tif.start[i]) begin
                cnt_ff <= tif.len[i];
            end else if (cnt_ff != '0) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
        // Restart wins over expiry so a new command never slips through
        assign tif.ready_next[i] = tif.start[i] ? (tif.len[i] == '0)
                                                : (cnt_ff <= W'(1));
    end
endmodule : cmd_timer_bank
`default_nettype wire

//--- src/idle_timer.sv
// Purpose: Counts idle cycles after the last transfer
// Assumes: busy_in high during every transfer
// Notes: Reserved code never expires
`timescale 1ns/1ps
`default_nettype none
module idle_timer
    import sdram_cfg_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic busy_in,
    input wire logic [1:0] code_in,
    output logic expired_out
);
    logic [7:0] cnt_ff;
    logic [7:0] limit;
    always_comb begin
        unique case (code_in)
            2'b00: limit = 8'h00;
            2'b01: limit = IDLE_SHORT;
            2'b10: limit = IDLE_LONG;
            default: limit = 8'hff;
        endcase
    end
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_ff <= '0;
        end else if (busy_in) begin
            cnt_ff <= '0;
        end else if (cnt_ff < limit) begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
    assign expired_out = (code_in != 2'b11) && !busy_in && (cnt_ff >= limit);
endmodule : idle_timer
`default_nettype wire

//--- bench/sdram_side_model.sv
// Purpose: Memory-side state model reacting to the low-power commands
// Assumes: Command pulses are one cycle wide
// Notes: Any rise of clock-enable wakes the part
`timescale 1ns/1ps
`default_nettype none
module sdram_side_model
    import sdram_cfg_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic sr_cmd_in,
    input wire logic pd_cmd_in,
    input wire logic dpd_cmd_in,
    input wire logic clk_en_in,
    output var lp_state_e state_out,
    output logic bad_out
);
    // --------------------------------
    // Device state
    // --------------------------------
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_out <= ST_ACTIVE;
            bad_out <= 1'b0;
        end else begin
            // A sleeping part cannot take a second command
            if ((sr_cmd_in | pd_cmd_in | dpd_cmd_in) && state_out != ST_ACTIVE)
                bad_out <= 1'b1;
            if (sr_cmd_in)
                state_out <= ST_SELF_REF;
            else if (pd_cmd_in)
                state_out <= ST_PWR_DOWN;
            else if (dpd_cmd_in)
                state_out <= ST_DEEP_PD;
            else if (clk_en_in)
                state_out <= ST_ACTIVE;
        end
    end
endmodule : sdram_side_model
`default_nettype wire

//--- bench/sdram_config_lowpower_irq_test.sv
// Purpose: Register, timer, low-power and irq tests of the config block
// Assumes: Plain register port, read data in the cycle after the strobe
// Notes: Idle timeout windows allow a few cycles of pipeline slack
`timescale 1ns/1ps
`default_nettype none
module sdram_config_lowpower_irq_test;
    import sdram_cfg_pkg::*;
    logic clk_sys_in, arst_n_in, rd, wr, req, busy, seen;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    logic [4:0] ev;
    logic [3:0] row_bits;
    logic [1:0] cas;
    logic [6:0] ext;
    logic four_banks, bus16, cmd_ok, act_ok, rw_ok, pre_ok, bad;
    logic sr_cmd, pd_cmd, dpd_cmd, cke, ck_run, lp_ready, irq;
    lp_state_e mem_state;
    int n_errors = 0, samples_checked = 0, cyc = 0, n;
    sdram_cfg_lowpower uut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .access_req_in(req),
        .transfer_busy_in(busy), .write_done_in(ev[0]),
        .refresh_issued_in(ev[1]), .precharge_issued_in(ev[2]),
        .activate_issued_in(ev[3]), .refresh_error_in(ev[4]),
        .row_bits_out(row_bits), .four_banks_out(four_banks),
        .cas_latency_out(cas), .bus16_out(bus16), .ext_mode_out(ext),
        .cmd_allowed_out(cmd_ok), .activate_allowed_out(act_ok),
        .rw_allowed_out(rw_ok), .precharge_allowed_out(pre_ok),
        .self_refresh_cmd_out(sr_cmd), .power_down_cmd_out(pd_cmd),
        .deep_pd_cmd_out(dpd_cmd), .memory_clk_en_out(cke),
        .memory_clock_run_out(ck_run), .lp_ready_out(lp_ready),
        .irq_out(irq));
    sdram_side_model mem (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .sr_cmd_in(sr_cmd), .pd_cmd_in(pd_cmd), .dpd_cmd_in(dpd_cmd),
        .clk_en_in(cke), .state_out(mem_state), .bad_out(bad));
    // --------------------------------
    // Helpers
    // --------------------------------
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
        @(posedge clk_sys_in);
        #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : rd_chk
    function automatic logic sel(input int k);
        case (k)
            0: return cmd_ok;
            1: return act_ok;
            2: return rw_ok;
            3: return pre_ok;
            4: return sr_cmd;
            5: return pd_cmd;
            default: return dpd_cmd;
        endcase
    endfunction : sel
    task automatic fire(input int b);
        @(posedge clk_sys_in);
        ev[b] <= 1'b1;
        @(posedge clk_sys_in);
        ev[b] <= 1'b0;
        #1;
    endtask : fire
    // Cycles a gating output stays low after one issue pulse
    task automatic low_len(input int b, input int k, output int len);
        fire(b);
        len = 0;
        while (sel(k) === 1'b0 && len < 20) begin
            @(posedge clk_sys_in);
            #1;
            len++;
        end
    endtask : low_len
    task automatic wait_hi(input int k, output int len);
        len = 0;
        while (sel(k) !== 1'b1 && len < 300) begin
            @(posedge clk_sys_in);
            #1;
            len++;
        end
    endtask : wait_hi
    task automatic step(input int c);
        repeat (c) @(posedge clk_sys_in);
        #1;
    endtask : step
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // Hang guard: the whole sequence needs under 5000 cycles
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        {arst_n_in, rd, wr, req, busy, ev, addr, wdata} = '0;
        repeat (6) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        check({row_bits, four_banks, cas, bus16}, 8'hb5);
        rd_chk(ADDR_GEOM, GEOM_RESET);
        rd_chk(ADDR_LOWPWR, 32'h0);
        rd_chk(8'h04, 32'h0);
        for (int i = 0; i < 3; i++) begin
            d = 32'h85237200 | 32'(i * 4 + 16 + (i + 1) * 32);
            wr_reg(ADDR_GEOM, d);
            check({row_bits, four_banks, cas, bus16}, 32'((11 + i) * 16 + 8 + (i + 1) * 2));
            rd_chk(ADDR_GEOM, d);
        end
        wr_reg(ADDR_GEOM, GEOM_RESET);
        low_len(0, 0, n); check(n, 2);
        low_len(1, 1, n); check(n, 7);
        low_len(2, 0, n); check(n, 3);
        low_len(3, 2, n); check(n, 2);
        low_len(3, 3, n); check(n, 5);
        wr_reg(ADDR_GEOM, 32'h85f372c0);
        low_len(3, 2, n); check(n, 15);
        wr_reg(ADDR_GEOM, 32'h850372c0);
        low_len(3, 2, n); check(n, 0);
        wr_reg(ADDR_GEOM, GEOM_RESET);
        wr_reg(ADDR_LOWPWR, 32'hffffc650);
        check(ext, 7'h35);
        rd_chk(ADDR_LOWPWR, 32'h650);
        seen = 1'b0;
        repeat (200) begin
            step(1);
            seen = seen | sr_cmd | pd_cmd | dpd_cmd;
        end
        check(seen, 1'b0);
        wr_reg(ADDR_LOWPWR, 32'h2);
        wait_hi(5, n); check({cke, lp_ready, ck_run}, 3'b001);
        step(1); check(mem_state, ST_PWR_DOWN);
        req <= 1'b1;
        step(1); check({cke, lp_ready}, 2'b11);
        req <= 1'b0;
        wait_hi(5, n); check(n < 300, 1'b1);
        wr_reg(ADDR_LOWPWR, 32'h1);
        wait_hi(4, n); check({cke, ck_run}, 2'b00);
        step(1); check(mem_state, ST_SELF_REF);
        req <= 1'b1;
        step(1); check({cke, ck_run, act_ok}, 3'b110);
        req <= 1'b0;
        wr_reg(ADDR_LOWPWR, 32'h3);
        wait_hi(6, n); check(ck_run, 1'b0);
        req <= 1'b1;
        step(20); check({lp_ready, mem_state}, {1'b0, ST_DEEP_PD});
        for (int c = 1; c < 4; c++) begin
            req <= 1'b1;
            wr_reg(ADDR_LOWPWR, 32'h2 | 32'(c * 4096));
            req <= 1'b0;
            wait_hi(5, n);
            check(c < 3 ? (n >= 64 * c - 1 && n <= 64 * c + 2) : (n == 300), 1'b1);
        end
        wr_reg(ADDR_LOWPWR, 32'h0);
        check(bad, 1'b0);
        wr_reg(ADDR_IRQ_EN, 32'h0);
        rd_chk(ADDR_IRQ_MASK, 32'h0);
        wr_reg(ADDR_IRQ_EN, 32'h1);
        rd_chk(ADDR_IRQ_MASK, 32'h1);
        fire(4); check(irq, 1'b1);
        rd_chk(ADDR_IRQ_STAT, 32'h1); check(irq, 1'b0);
        rd_chk(ADDR_IRQ_STAT, 32'h0);
        wr_reg(ADDR_IRQ_DIS, 32'h0);
        rd_chk(ADDR_IRQ_MASK, 32'h1);
        wr_reg(ADDR_IRQ_DIS, 32'h1);
        rd_chk(ADDR_IRQ_MASK, 32'h0);
        fire(4); check(irq, 1'b0);
        rd_chk(ADDR_IRQ_STAT, 32'h1);
        wr_reg(ADDR_IRQ_MASK, 32'h1);
        rd_chk(ADDR_IRQ_MASK, 32'h0);
        give_verdict();
    end
endmodule : sdram_config_lowpower_irq_test
`default_nettype wire
